// [hbc_pkg.sv]
package hbc_pkg;

    // Configuration offsets (byte addresses as printed)
    localparam logic [7:0] HBC_OFF_MAKER = 8'h00;
    localparam logic [7:0] HBC_OFF_PART = 8'h02;
    localparam logic [7:0] HBC_OFF_CONTROL = 8'h04;
    localparam logic [7:0] HBC_OFF_FLAGS = 8'h06;
    localparam logic [7:0] HBC_OFF_REVISION = 8'h08;
    localparam logic [7:0] HBC_OFF_PROG_IF = 8'h09;
    localparam logic [7:0] HBC_OFF_SUBCLASS = 8'h0a;
    localparam logic [7:0] HBC_OFF_BASE_CLASS = 8'h0b;
    localparam logic [7:0] HBC_OFF_LINE_SIZE = 8'h0c;

    // Dword indices that hold the above
    localparam logic [5:0] HBC_DW_IDENT = 6'h00;
    localparam logic [5:0] HBC_DW_CTRL_FLAGS = 6'h01;
    localparam logic [5:0] HBC_DW_CLASS = 6'h02;
    localparam logic [5:0] HBC_DW_MISC = 6'h03;

    // Control register bit positions
    localparam int HBC_CTL_IO_EN = 0;
    localparam int HBC_CTL_MEM_EN = 1;
    localparam int HBC_CTL_MASTER_EN = 2;
    localparam int HBC_CTL_SYSTEM_ERROR_ENABLE = 8;

    // Flag register bit positions
    localparam int HBC_FLG_CAP = 4;
    localparam int HBC_FLG_66MHZ = 5;
    localparam int HBC_FLG_SEL_LO = 9;
    localparam int HBC_FLG_TGT_ABORT = 12;
    localparam int HBC_FLG_MST_ABORT = 13;
    localparam int HBC_FLG_SYS_ERR = 14;

    // Sticky flag bank index
    localparam int HBC_EV_TGT = 0;
    localparam int HBC_EV_MST = 1;
    localparam int HBC_EV_SERR = 2;
    localparam int HBC_EV_COUNT = 3;

    // Fixed and reset values
    localparam logic [15:0] HBC_CTL_FIXED = 16'h0004;
    localparam logic [15:0] HBC_FLG_FIXED = 16'h0230;
    localparam logic [1:0] HBC_SELECT_TIMING = 2'h1;
    localparam logic [7:0] HBC_PROG_IF_VAL = 8'h00;
    localparam logic [7:0] HBC_SUBCLASS_VAL = 8'h00;
    localparam logic [7:0] HBC_BASE_CLASS_VAL = 8'h06;
    localparam logic [7:0] HBC_LINE_SIZE_VAL = 8'h00;
    localparam logic HBC_MEM_EN_RESET = 1'b0;
    localparam logic HBC_SYSTEM_ERROR_ENABLE_RESET = 1'b0;

    // Configuration access request
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] offset;
        logic [3:0] byte_en;
        logic [31:0] wdata;
    } hbc_cfg_req_type;

endpackage

// [hbc_flag_bank.sv]
`timescale 1ns/10ps
module hbc_flag_bank #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Events and clears
    input wire logic [WIDTH-1:0] set_in,
    input wire logic [WIDTH-1:0] clr_in,
    // Sticky flags
    output logic [WIDTH-1:0] flags_out
);
    logic [WIDTH-1:0] flags_reg;
    logic [WIDTH-1:0] flags_next;

    // Set beats clear so no event is lost in a clear cycle
    generate
        for (genvar i = 0; i < WIDTH; i++) begin : g_flag
            always_comb begin
                flags_next[i] = set_in[i] | (flags_reg[i] & ~clr_in[i]);
            end
        end
    endgenerate

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags_out = flags_reg;
endmodule

// [hbc_config_header.sv]
`timescale 1ns/10ps
// Functional notes
// - Maker code at offset zero, read-only
// - Part code picks primary or alternate by fuse
// - I/O enable reads 0, no I/O response
// - Memory enable writable, resets 0, gates access
// - Bus master enable always reads 1
// - Special cycle, invalidate, snoop, parity bits zero
// - System error enable gates error pin drive
// - Back-to-back enable and bits 15:10 zero
// - Capabilities present bit reads 1
// - 66 MHz capable bit reads 1
// - Back-to-back capable status bit reads 0
// - Select timing field reads medium (1)
// - Signaled target abort reads 0
// - Target abort received sets flag, write-1 clears
// - Master abort received sets flag, write-1 clears
// - Raised system error sets flag, write-1 clears
// - Detected parity error reads 0
// - Revision: stepping low nibble, revision high
// - Class bytes read-only, bridge host class
module hbc_config_header #(
    parameter logic [15:0] MAKER_CODE = 16'h1ab0,       // Arbitrary value
    parameter logic [15:0] PART_CODE_PRIMARY = 16'h2c10, // Arbitrary value
    parameter logic [15:0] PART_CODE_ALT = 16'h2c11,    // Arbitrary value
    parameter logic [3:0] STEPPING_NUMBER = 4'h0,
    parameter logic [3:0] REVISION_NUMBER = 4'h0
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Configuration access
    input wire hbc_pkg::hbc_cfg_req_type cfg_req_in,
    output logic cfg_ack_out,
    output logic [31:0] cfg_rdata_out,
    // Fuse strap and bridge events
    input wire logic alt_id_fuse_in,
    input wire logic target_abort_in,
    input wire logic master_abort_in,
    input wire logic special_cycle_in,
    input wire logic address_remap_table_error_in,
    // Bridge controls
    output logic mem_space_enable_out,
    output logic io_respond_out,
    output logic bus_master_enable_out,
    output logic serr_drive_out
);
    import hbc_pkg::*;

    logic [1:0] rst_sync_reg;
    logic rst_n_sync;
    logic fuse_meta_reg;
    logic fuse_sync_reg;

    // Reset release through two flops, assert stays asynchronous
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n_sync = rst_sync_reg[1];

    // Fuse level comes from a pin, so synchronise before use
    always_ff @(posedge sys_clk_in or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            fuse_meta_reg <= 1'b0;
            fuse_sync_reg <= 1'b0;
        end else begin
            fuse_meta_reg <= alt_id_fuse_in;
            fuse_sync_reg <= fuse_meta_reg;
        end
    end

    logic [5:0] dw_index;
    logic rd_hit_ctrl;
    logic wr_ctrl;
    assign dw_index = cfg_req_in.offset[7:2];
    assign wr_ctrl = cfg_req_in.valid && cfg_req_in.write && (dw_index == HBC_DW_CTRL_FLAGS);
    assign rd_hit_ctrl = cfg_req_in.valid && !cfg_req_in.write;

    // Writable control bits
    logic mem_en_reg;
    logic mem_en_next;
    logic system_error_enable_reg;
    logic system_error_enable_next;

    always_comb begin
        mem_en_next = mem_en_reg;
        system_error_enable_next = system_error_enable_reg;
        if (wr_ctrl && cfg_req_in.byte_en[0]) begin
            mem_en_next = cfg_req_in.wdata[HBC_CTL_MEM_EN];
        end
        if (wr_ctrl && cfg_req_in.byte_en[1]) begin
            system_error_enable_next = cfg_req_in.wdata[HBC_CTL_SYSTEM_ERROR_ENABLE];
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            mem_en_reg <= HBC_MEM_EN_RESET;
            system_error_enable_reg <= HBC_SYSTEM_ERROR_ENABLE_RESET;
        end else begin
            mem_en_reg <= mem_en_next;
            system_error_enable_reg <= system_error_enable_next;
        end
    end

    // Sticky abort and error flags
    logic [HBC_EV_COUNT-1:0] ev_set;
    logic [HBC_EV_COUNT-1:0] ev_clr;
    logic [HBC_EV_COUNT-1:0] flags;
    logic serr_raise;

    assign serr_raise = address_remap_table_error_in && system_error_enable_reg;
    assign ev_set[HBC_EV_TGT] = target_abort_in && !special_cycle_in;
    assign ev_set[HBC_EV_MST] = master_abort_in && !special_cycle_in;
    assign ev_set[HBC_EV_SERR] = serr_raise;
    // Only a written 1 in the top status byte clears
    assign ev_clr[HBC_EV_TGT] = wr_ctrl && cfg_req_in.byte_en[3]
        && cfg_req_in.wdata[16+HBC_FLG_TGT_ABORT];
    assign ev_clr[HBC_EV_MST] = wr_ctrl && cfg_req_in.byte_en[3]
        && cfg_req_in.wdata[16+HBC_FLG_MST_ABORT];
    assign ev_clr[HBC_EV_SERR] = wr_ctrl && cfg_req_in.byte_en[3]
        && cfg_req_in.wdata[16+HBC_FLG_SYS_ERR];

    hbc_flag_bank #(
        .WIDTH(HBC_EV_COUNT)
    ) u_flags (
        .clk_in(sys_clk_in),
        .rst_n_in(rst_n_sync),
        .set_in(ev_set),
        .clr_in(ev_clr),
        .flags_out(flags)
    );

    // Register views; hardwired bits come from the fixed patterns
    logic [15:0] ctrl_view;
    logic [15:0] flag_view;
    logic [15:0] part_code;
    always_comb begin
        ctrl_view = HBC_CTL_FIXED;
        ctrl_view[HBC_CTL_MEM_EN] = mem_en_reg;
        ctrl_view[HBC_CTL_SYSTEM_ERROR_ENABLE] = system_error_enable_reg;
        flag_view = HBC_FLG_FIXED;
        flag_view[HBC_FLG_TGT_ABORT] = flags[HBC_EV_TGT];
        flag_view[HBC_FLG_MST_ABORT] = flags[HBC_EV_MST];
        flag_view[HBC_FLG_SYS_ERR] = flags[HBC_EV_SERR];
        part_code = fuse_sync_reg ? PART_CODE_ALT : PART_CODE_PRIMARY;
    end

    // Read answer and bridge outputs, all registered
    logic ack_reg;
    logic ack_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic serr_drv_reg;
    logic serr_drv_next;

    always_comb begin
        ack_next = cfg_req_in.valid;
        rdata_next = 32'h0;
        serr_drv_next = serr_raise;
        if (rd_hit_ctrl) begin
            case (dw_index)
                HBC_DW_IDENT: begin
                    rdata_next = {part_code, MAKER_CODE};
                end
                HBC_DW_CTRL_FLAGS: begin
                    rdata_next = {flag_view, ctrl_view};
                end
                HBC_DW_CLASS: begin
                    rdata_next = {HBC_BASE_CLASS_VAL, HBC_SUBCLASS_VAL,
                        HBC_PROG_IF_VAL, REVISION_NUMBER, STEPPING_NUMBER};
                end
                HBC_DW_MISC: begin
                    rdata_next = {24'h0, HBC_LINE_SIZE_VAL};
                end
                default: begin
                    rdata_next = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0;
            serr_drv_reg <= 1'b0;
        end else begin
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
            serr_drv_reg <= serr_drv_next;
        end
    end

    // I/O never answered, master always allowed: constant flops
    logic io_resp_reg;
    logic master_reg;
    always_ff @(posedge sys_clk_in or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            io_resp_reg <= 1'b0;
            master_reg <= 1'b1;
        end else begin
            io_resp_reg <= 1'b0;
            master_reg <= 1'b1;
        end
    end

    assign cfg_ack_out = ack_reg;
    assign cfg_rdata_out = rdata_reg;
    assign mem_space_enable_out = mem_en_reg;
    assign io_respond_out = io_resp_reg;
    assign bus_master_enable_out = master_reg;
    assign serr_drive_out = serr_drv_reg;

    logic rd0;
    logic rd1;
    logic rd2;
    assign rd0 = rd_hit_ctrl && dw_index == HBC_DW_IDENT;
    assign rd1 = rd_hit_ctrl && dw_index == HBC_DW_CTRL_FLAGS;
    assign rd2 = rd_hit_ctrl && dw_index == HBC_DW_CLASS;

    property p_maker;
        @(posedge sys_clk_in) disable iff (!rst_n_sync)
        rd0 |=> cfg_ack_out && cfg_rdata_out[15:0] == MAKER_CODE;
    endproperty
    a_maker: assert property (p_maker) else $error("maker code wrong");

    property p_part;
        @(posedge sys_clk_in) disable iff (!rst_n_sync)
        rd0 |=> cfg_rdata_out[31:16] ==
            ($past(fuse_sync_reg) ? PART_CODE_ALT : PART_CODE_PRIMARY);
    endproperty
    a_part: assert property (p_part) else $error("part code wrong");

    property p_ctrl_fixed;
        @(posedge sys_clk_in) disable iff (!rst_n_sync)
        rd1 |=> cfg_rdata_out[0] == 1'b0 && cfg_rdata_out[2] == 1'b1
            && cfg_rdata_out[7:3] == 5'h0 && cfg_rdata_out[15:9] == 7'h0 && !io_respond_out;
    endproperty
    a_ctrl_fixed: assert property (p_ctrl_fixed) else $error("control fixed bits");

    property p_mem_en;
        @(posedge sys_clk_in) disable iff (!rst_n_sync)
        wr_ctrl && cfg_req_in.byte_en[0] |=>
            mem_space_enable_out == $past(cfg_req_in.wdata[1]) && bus_master_enable_out;
    endproperty
    a_mem_en: assert property (p_mem_en) else $error("memory enable write lost");

    property p_serr_gate;
        @(posedge sys_clk_in) disable iff (!rst_n_sync)
        serr_drive_out |-> $past(system_error_enable_reg) && $past(address_remap_table_error_in);
    endproperty
    a_serr_gate: assert property (p_serr_gate) else $error("error pin without enable");

    property p_flag_fixed;
        @(posedge sys_clk_in) disable iff (!rst_n_sync)
        rd1 |=> cfg_rdata_out[20] && cfg_rdata_out[21] && !cfg_rdata_out[23]
            && cfg_rdata_out[26:25] == HBC_SELECT_TIMING && !cfg_rdata_out[27]
            && !cfg_rdata_out[31];
    endproperty
    a_flag_fixed: assert property (p_flag_fixed) else $error("status fixed bits");

    property p_tgt_set;
        @(posedge sys_clk_in) disable iff (!rst_n_sync)
        target_abort_in && !special_cycle_in ##1 rd1 |=> cfg_rdata_out[28];
    endproperty
    a_tgt_set: assert property (p_tgt_set) else $error("target abort flag missed");

    property p_mst_set;
        @(posedge sys_clk_in) disable iff (!rst_n_sync)
        master_abort_in && !special_cycle_in |=> flags[HBC_EV_MST];
    endproperty
    a_mst_set: assert property (p_mst_set) else $error("master abort flag missed");

    property p_serr_flag;
        @(posedge sys_clk_in) disable iff (!rst_n_sync)
        serr_drive_out |-> flags[HBC_EV_SERR];
    endproperty
    a_serr_flag: assert property (p_serr_flag) else $error("error flag not set");

    property p_write_zero_keeps;
        @(posedge sys_clk_in) disable iff (!rst_n_sync)
        flags[HBC_EV_TGT] && wr_ctrl && !cfg_req_in.wdata[28] |=> flags[HBC_EV_TGT];
    endproperty
    a_write_zero_keeps: assert property (p_write_zero_keeps) else $error("flag lost");

    property p_class;
        @(posedge sys_clk_in) disable iff (!rst_n_sync)
        rd2 |=> cfg_rdata_out == {24'h060000, REVISION_NUMBER, STEPPING_NUMBER};
    endproperty
    a_class: assert property (p_class) else $error("class or revision wrong");

    // A written 1 must clear unless a fresh abort arrives in the same cycle
    property p_tgt_clear;
        @(posedge sys_clk_in) disable iff (!rst_n_sync)
        wr_ctrl && cfg_req_in.byte_en[3] && cfg_req_in.wdata[16+HBC_FLG_TGT_ABORT]
            && !target_abort_in |=> !flags[HBC_EV_TGT];
    endproperty
    a_tgt_clear: assert property (p_tgt_clear) else $error("flag not cleared");

    property p_spc_ignore;
        @(posedge sys_clk_in) disable iff (!rst_n_sync)
        !flags[HBC_EV_MST] && special_cycle_in |=> !flags[HBC_EV_MST];
    endproperty
    a_spc_ignore: assert property (p_spc_ignore) else $error("special abort set");

    property p_system_error_enable_wr;
        @(posedge sys_clk_in) disable iff (!rst_n_sync)
        wr_ctrl && cfg_req_in.byte_en[1] |=>
            system_error_enable_reg == $past(cfg_req_in.wdata[HBC_CTL_SYSTEM_ERROR_ENABLE]);
    endproperty
    a_system_error_enable_wr: assert property (p_system_error_enable_wr) else $error("enable write lost");
endmodule

// [hbc_config_header_tb_top.sv]
`timescale 1ns/10ps
module hbc_config_header_tb_top;
    import hbc_pkg::*;

    // Part codes and revision for this bench, values arbitrary
    localparam logic [15:0] T_MAKER = 16'h3e51;
    localparam logic [15:0] T_PART_P = 16'h4d20;
    localparam logic [15:0] T_PART_A = 16'h4d21;
    localparam logic [3:0] T_STEP = 4'h3;
    localparam logic [3:0] T_REV = 4'h5;

    logic sys_clk_in;
    logic rst_n_in;
    hbc_cfg_req_type cfg_req;
    logic cfg_ack;
    logic [31:0] cfg_rdata;
    logic alt_fuse;
    logic tgt_abort;
    logic mst_abort;
    logic special_cycle;
    logic remap_err;
    logic mem_en;
    logic io_resp;
    logic bm_en;
    logic serr_drive;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;

    hbc_config_header #(
        .MAKER_CODE(T_MAKER),
        .PART_CODE_PRIMARY(T_PART_P),
        .PART_CODE_ALT(T_PART_A),
        .STEPPING_NUMBER(T_STEP),
        .REVISION_NUMBER(T_REV)
    ) hbc_config_header_inst (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .cfg_req_in(cfg_req),
        .cfg_ack_out(cfg_ack),
        .cfg_rdata_out(cfg_rdata),
        .alt_id_fuse_in(alt_fuse),
        .target_abort_in(tgt_abort),
        .master_abort_in(mst_abort),
        .special_cycle_in(special_cycle),
        .address_remap_table_error_in(remap_err),
        .mem_space_enable_out(mem_en),
        .io_respond_out(io_resp),
        .bus_master_enable_out(bm_en),
        .serr_drive_out(serr_drive)
    );

    // Free-running core clock
    initial begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end

    // Verdict in one place
    task automatic close_out();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Four-state compare so an unknown never matches
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One access; ack and data sampled half a cycle after the answering edge
    task automatic cfg(input logic wr, input logic [7:0] off, input logic [3:0] be,
                       input logic [31:0] wd, output logic [31:0] rdat);
        cfg_req = '{valid: 1'b1, write: wr, offset: off, byte_en: be, wdata: wd};
        @(negedge sys_clk_in);
        check("ack", {31'h0, cfg_ack}, 32'h1);
        rdat = cfg_rdata;
        cfg_req = '0;
        // Idle cycle so valid is never driven twice in one step
        @(negedge sys_clk_in);
    endtask

    task automatic rd_chk(input logic [7:0] off, input logic [31:0] exp, input string name);
        logic [31:0] v;
        cfg(1'b0, off, 4'hf, 32'h0, v);
        check(name, v, exp);
    endtask

    task automatic wr(input logic [7:0] off, input logic [3:0] be, input logic [31:0] wd);
        logic [31:0] v;
        cfg(1'b1, off, be, wd, v);
        check("wr_data", v, 32'h0);
    endtask

    // Hang guard, far above the roughly 85 cycles needed
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            close_out();
        end
    end

    // Main sequence
    initial begin
        cfg_req = '0;
        rst_n_in = 1'b0;
        alt_fuse = 1'b0;
        tgt_abort = 1'b0;
        mst_abort = 1'b0;
        special_cycle = 1'b0;
        remap_err = 1'b0;
        repeat (8) @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        // Two-flop release, first request on the third edge
        repeat (3) @(negedge sys_clk_in);
        check("mem_en", {31'h0, mem_en}, 32'h0);
        check("io_resp", {31'h0, io_resp}, 32'h0);
        check("bm_en", {31'h0, bm_en}, 32'h1);
        check("serr", {31'h0, serr_drive}, 32'h0);
        // Identity dword, then a write that must not stick
        rd_chk(HBC_OFF_MAKER, {T_PART_P, T_MAKER}, "ident");
        wr(HBC_OFF_MAKER, 4'hf, 32'hffff_ffff);
        rd_chk(HBC_OFF_MAKER, {T_PART_P, T_MAKER}, "ident_wr");
        rd_chk(HBC_OFF_CONTROL, 32'h0230_0004, "ctl_rst");
        // All ones: only memory and error enables take
        wr(HBC_OFF_CONTROL, 4'hf, 32'hffff_ffff);
        check("mem_en", {31'h0, mem_en}, 32'h1);
        check("io_resp", {31'h0, io_resp}, 32'h0);
        rd_chk(HBC_OFF_CONTROL, 32'h0230_0106, "ctl_ones");
        rd_chk(HBC_OFF_REVISION, {8'h06, 8'h00, 8'h00, T_REV, T_STEP}, "class");
        wr(HBC_OFF_REVISION, 4'hf, 32'hffff_ffff);
        rd_chk(HBC_OFF_REVISION, {8'h06, 8'h00, 8'h00, T_REV, T_STEP}, "class_wr");
        rd_chk(HBC_OFF_LINE_SIZE, 32'h0, "line");
        // Aborts during a special cycle are ignored
        special_cycle = 1'b1;
        tgt_abort = 1'b1;
        mst_abort = 1'b1;
        @(negedge sys_clk_in);
        special_cycle = 1'b0;
        tgt_abort = 1'b0;
        mst_abort = 1'b0;
        rd_chk(HBC_OFF_CONTROL, 32'h0230_0106, "abort_spc");
        tgt_abort = 1'b1;
        @(negedge sys_clk_in);
        tgt_abort = 1'b0;
        rd_chk(HBC_OFF_CONTROL, 32'h1230_0106, "tgt_set");
        mst_abort = 1'b1;
        @(negedge sys_clk_in);
        mst_abort = 1'b0;
        rd_chk(HBC_OFF_CONTROL, 32'h3230_0106, "mst_set");
        // Writing zero keeps flags; one clears only its own bit
        wr(HBC_OFF_CONTROL, 4'h8, 32'h0);
        rd_chk(HBC_OFF_CONTROL, 32'h3230_0106, "w0_keep");
        wr(HBC_OFF_CONTROL, 4'h8, 32'h1000_0000);
        rd_chk(HBC_OFF_CONTROL, 32'h2230_0106, "tgt_clr");
        wr(HBC_OFF_CONTROL, 4'h8, 32'h2000_0000);
        rd_chk(HBC_OFF_CONTROL, 32'h0230_0106, "mst_clr");
        // Error while enabled drives the pin and sets the flag
        remap_err = 1'b1;
        @(negedge sys_clk_in);
        check("serr_on", {31'h0, serr_drive}, 32'h1);
        remap_err = 1'b0;
        @(negedge sys_clk_in);
        check("serr_off", {31'h0, serr_drive}, 32'h0);
        rd_chk(HBC_OFF_CONTROL, 32'h4230_0106, "serr_flag");
        wr(HBC_OFF_CONTROL, 4'h8, 32'h4000_0000);
        wr(HBC_OFF_CONTROL, 4'h2, 32'h0);
        // Error while disabled neither drives nor flags
        remap_err = 1'b1;
        @(negedge sys_clk_in);
        check("serr_dis", {31'h0, serr_drive}, 32'h0);
        remap_err = 1'b0;
        @(negedge sys_clk_in);
        rd_chk(HBC_OFF_CONTROL, 32'h0230_0006, "serr_gate");
        // Lane 0 only: bit 8 sits in lane 1 and must not take
        wr(HBC_OFF_CONTROL, 4'h1, 32'h0000_0100);
        check("mem_en", {31'h0, mem_en}, 32'h0);
        rd_chk(HBC_OFF_CONTROL, 32'h0230_0004, "lane0");
        // Fuse passes a two-flop synchroniser before use
        alt_fuse = 1'b1;
        repeat (4) @(negedge sys_clk_in);
        rd_chk(HBC_OFF_MAKER, {T_PART_A, T_MAKER}, "ident_alt");
        // Mid-run reset must drop the enable and the sticky flag
        wr(HBC_OFF_CONTROL, 4'h1, 32'h0000_0002);
        tgt_abort = 1'b1;
        @(negedge sys_clk_in);
        tgt_abort = 1'b0;
        rd_chk(HBC_OFF_CONTROL, 32'h1230_0006, "pre_rst");
        rst_n_in = 1'b0;
        @(negedge sys_clk_in);
        check("mem_rst", {31'h0, mem_en}, 32'h0);
        check("bm_rst", {31'h0, bm_en}, 32'h1);
        rst_n_in = 1'b1;
        repeat (3) @(negedge sys_clk_in);
        rd_chk(HBC_OFF_CONTROL, 32'h0230_0004, "ctl_rst2");
        close_out();
    end
endmodule
